// ### include/iop_consts.svh
// register offsets, field positions, reset values and timing counts for the io port block
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH
// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define IOP_A_OUT 8'h00
`define IOP_A_DIR 8'h01
`define IOP_A_OD 8'h02
`define IOP_A_IN 8'h03
`define IOP_PU_GRP 8'h04
`define IOP_B_PU 8'h05
`define IOP_B_IN 8'h06
`define IOP_C_OUT 8'h07
`define IOP_C_DIR 8'h08
`define IOP_C_OD 8'h09
`define IOP_C_IN 8'h0A
`define IOP_AC_WIDE 8'h0B
`define IOP_E_OUT 8'h0C
`define IOP_E_DIR 8'h0D
`define IOP_E_OD 8'h0E
`define IOP_E_IN 8'h0F
`define IOP_SEG_OUT 8'h10
`define IOP_EDGE_SEL 8'h11
`define IOP_IRQ_ST 8'h12
`define IOP_IRQ_MASK 8'h13
`define IOP_BUZ_CTRL 8'h14
`define IOP_BIT_WR 8'h15
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define IOP_PU_A 0
`define IOP_PU_C 1
`define IOP_PU_E 2
`define IOP_SEL_EXTA 4
`define IOP_SEL_EXTB 5
`define IOP_SEL_QUASI 6
`define IOP_ST_KEY 0
`define IOP_ST_EXTA 1
`define IOP_ST_EXTB 2
`define IOP_ST_QUASI 3
`define IOP_ST_BOTH 4
`define IOP_BUZ_EN 0
`define IOP_BW_PORT_HI 7
`define IOP_BW_PORT_LO 6
`define IOP_BW_IDX_HI 5
`define IOP_BW_IDX_LO 3
`define IOP_BW_VAL 0
// ------------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------------
`define IOP_RST_MASK 5'h00
`define IOP_RST_SEL 7'h00
`define IOP_CLK_HZ 100000000
`define IOP_WATCH_HZ 32768
`define IOP_WATCH_DIV ((`IOP_CLK_HZ + `IOP_WATCH_HZ / 2) / `IOP_WATCH_HZ)
`endif

// ### include/iop_pkg.sv
// types for the io port block
package iop_pkg;
  typedef struct packed {
    logic [3:0] a_out, a_dir, a_od;
    logic [3:0] c_out, c_dir, c_od;
    logic [2:0] e_out, e_dir, e_od;
    logic [2:0] pu_grp;
    logic [3:0] b_pu;
    logic [7:0] seg;
    logic [6:0] edge_sel;
    logic [4:0] status, mask;
    logic [2:0] buz_ctrl;
    logic [7:0] sync1, sync2, prev;
    logic [11:0] wdiv;
    logic [3:0] bcnt;
    logic [7:0] rdata;
    logic irq, buzzer_output;
    logic [3:0] a_o, a_oe, a_pu;
    logic [3:0] c_o, c_oe, c_pu;
    logic [2:0] e_o, e_oe, e_pu;
  } iop_state_t;
endpackage : iop_pkg

// ### logic/iop_ports.sv
// io ports with edge interrupts and buzzer output
//
// What this block does
// - nibble port A, bit or nibble access
// - per-pin direction on bidirectional ports
// - per-pin open-drain or push-pull drive
// - group pull-ups, forced off on outputs
// - input-only nibble port, readable, never driven
// - per-pin pull-ups on input-only port
// - port C like A, plus 8-bit access
// - three-pin port with same features
// - eight output pins shared with segments
// - key inputs interrupt on selected edge
// - two external inputs on selected edge
// - quasi input sets flag, no interrupt
// - fourth input interrupts on both edges
// - buzzer 2k to 16k from watch clock
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "iop_consts.svh"
module iop_ports #(
  parameter int WATCH_DIV = `IOP_WATCH_DIV
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // nibble port A
  input wire logic [3:0] NIBBLE_PORT_A_PINS_I,
  output logic [3:0] NIBBLE_PORT_A_PINS_O,
  output logic [3:0] NIBBLE_PORT_A_PINS_OE,
  output logic [3:0] NIBBLE_PORT_A_PINS_PU,
  // input-only port
  input wire logic [3:0] INPUT_ONLY_PORT_PINS_I,
  output logic [3:0] INPUT_ONLY_PORT_PINS_PU,
  // nibble port C
  input wire logic [3:0] NIBBLE_PORT_C_PINS_I,
  output logic [3:0] NIBBLE_PORT_C_PINS_O,
  output logic [3:0] NIBBLE_PORT_C_PINS_OE,
  output logic [3:0] NIBBLE_PORT_C_PINS_PU,
  // three-pin port
  input wire logic [2:0] THREE_PIN_PORT_PINS_I,
  output logic [2:0] THREE_PIN_PORT_PINS_O,
  output logic [2:0] THREE_PIN_PORT_PINS_OE,
  output logic [2:0] THREE_PIN_PORT_PINS_PU,
  // segment shared outputs, interrupt and buzzer
  output logic [7:0] SEGMENT_SHARED_OUTPUT_PINS,
  output logic IRQ,
  output logic BUZZER_OUTPUT
);
  import iop_pkg::*;

  // ------------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------------
  if (WATCH_DIV < 2 || WATCH_DIV > 4095) begin : g_bad_div
    $error("WATCH_DIV must lie in 2..4095");
  end

  localparam logic [11:0] DIV_LAST = 12'(WATCH_DIV - 1);

  iop_state_t s_q;
  iop_state_t s_d;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [4:0] ev;
  logic tick;
  logic [2:0] bidx;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // edge pins go to sync1 here, and raw into rdata on reads; sync1 is read by sync2 alone
    s_d.sync1 = {INPUT_ONLY_PORT_PINS_I, NIBBLE_PORT_A_PINS_I};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    rise = s_q.sync2 & ~s_q.prev;
    fall = ~s_q.sync2 & s_q.prev;
    bidx = WDATA[`IOP_BW_IDX_HI:`IOP_BW_IDX_LO];

    if (WR) begin
      case (ADDR)
        `IOP_A_OUT: s_d.a_out = WDATA[3:0];
        `IOP_A_DIR: s_d.a_dir = WDATA[3:0];
        `IOP_A_OD: s_d.a_od = WDATA[3:0];
        `IOP_PU_GRP: s_d.pu_grp = WDATA[2:0];
        `IOP_B_PU: s_d.b_pu = WDATA[3:0];
        `IOP_C_OUT: s_d.c_out = WDATA[3:0];
        `IOP_C_DIR: s_d.c_dir = WDATA[3:0];
        `IOP_C_OD: s_d.c_od = WDATA[3:0];
        `IOP_AC_WIDE: begin
          s_d.c_out = WDATA[7:4];
          s_d.a_out = WDATA[3:0];
        end
        `IOP_E_OUT: s_d.e_out = WDATA[2:0];
        `IOP_E_DIR: s_d.e_dir = WDATA[2:0];
        `IOP_E_OD: s_d.e_od = WDATA[2:0];
        `IOP_SEG_OUT: s_d.seg = WDATA;
        `IOP_EDGE_SEL: s_d.edge_sel = WDATA[6:0];
        `IOP_IRQ_MASK: s_d.mask = WDATA[4:0];
        `IOP_BUZ_CTRL: s_d.buz_ctrl = WDATA[2:0];
        `IOP_BIT_WR: begin
          // single-bit write; index above a port's width is ignored
          case (WDATA[`IOP_BW_PORT_HI:`IOP_BW_PORT_LO])
            2'h0: if (bidx < 3'h4) s_d.a_out[bidx[1:0]] = WDATA[`IOP_BW_VAL];
            2'h1: if (bidx < 3'h4) s_d.c_out[bidx[1:0]] = WDATA[`IOP_BW_VAL];
            2'h2: if (bidx < 3'h3) s_d.e_out[bidx[1:0]] = WDATA[`IOP_BW_VAL];
            default: s_d.seg[bidx] = WDATA[`IOP_BW_VAL];
          endcase
        end
        default: ;
      endcase
    end

    // ------------------------------------------------------------------
    // edge events
    // ------------------------------------------------------------------
    ev = 5'h00;
    ev[`IOP_ST_KEY] = |((rise[3:0] & s_q.edge_sel[3:0])
                        | (fall[3:0] & ~s_q.edge_sel[3:0]));
    ev[`IOP_ST_EXTA] = s_q.edge_sel[`IOP_SEL_EXTA] ? rise[4] : fall[4];
    ev[`IOP_ST_EXTB] = s_q.edge_sel[`IOP_SEL_EXTB] ? rise[5] : fall[5];
    ev[`IOP_ST_QUASI] = s_q.edge_sel[`IOP_SEL_QUASI] ? rise[6] : fall[6];
    ev[`IOP_ST_BOTH] = rise[7] | fall[7];
    // a new event wins over the clear-on-read
    s_d.status = ((RD && ADDR == `IOP_IRQ_ST) ? 5'h00 : s_q.status) | ev;
    // quasi flag is polled only, it never drives the line
    s_d.irq = |(s_d.status & s_d.mask & ~(5'h01 << `IOP_ST_QUASI));

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------
    s_d.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        `IOP_A_OUT: s_d.rdata = {4'h0, s_q.a_out};
        `IOP_A_DIR: s_d.rdata = {4'h0, s_q.a_dir};
        `IOP_A_OD: s_d.rdata = {4'h0, s_q.a_od};
        `IOP_A_IN: s_d.rdata = {4'h0, NIBBLE_PORT_A_PINS_I};
        `IOP_PU_GRP: s_d.rdata = {5'h00, s_q.pu_grp};
        `IOP_B_PU: s_d.rdata = {4'h0, s_q.b_pu};
        `IOP_B_IN: s_d.rdata = {4'h0, INPUT_ONLY_PORT_PINS_I};
        `IOP_C_OUT: s_d.rdata = {4'h0, s_q.c_out};
        `IOP_C_DIR: s_d.rdata = {4'h0, s_q.c_dir};
        `IOP_C_OD: s_d.rdata = {4'h0, s_q.c_od};
        `IOP_C_IN: s_d.rdata = {4'h0, NIBBLE_PORT_C_PINS_I};
        `IOP_AC_WIDE: s_d.rdata = {NIBBLE_PORT_C_PINS_I, NIBBLE_PORT_A_PINS_I};
        `IOP_E_OUT: s_d.rdata = {5'h00, s_q.e_out};
        `IOP_E_DIR: s_d.rdata = {5'h00, s_q.e_dir};
        `IOP_E_OD: s_d.rdata = {5'h00, s_q.e_od};
        `IOP_E_IN: s_d.rdata = {5'h00, THREE_PIN_PORT_PINS_I};
        `IOP_SEG_OUT: s_d.rdata = s_q.seg;
        `IOP_EDGE_SEL: s_d.rdata = {1'b0, s_q.edge_sel};
        `IOP_IRQ_ST: s_d.rdata = {3'h0, s_q.status};
        `IOP_IRQ_MASK: s_d.rdata = {3'h0, s_q.mask};
        `IOP_BUZ_CTRL: s_d.rdata = {5'h00, s_q.buz_ctrl};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // ------------------------------------------------------------------
    // buzzer: watch tick divider, then binary stages
    // ------------------------------------------------------------------
    // 100 MHz does not divide evenly; the watch rate is off by under 0.01 %
    tick = (s_q.wdiv == DIV_LAST);
    s_d.wdiv = tick ? 12'h000 : s_q.wdiv + 12'h001;
    if (!s_q.buz_ctrl[`IOP_BUZ_EN]) begin
      s_d.bcnt = 4'h0;
    end else if (tick) begin
      s_d.bcnt = s_q.bcnt + 4'h1;
    end
    // stage k toggles at 32768/2^(k+1) hz: select 0 gives 2 khz, 3 gives 16 khz
    s_d.buzzer_output = s_d.bcnt[2'h3 - s_d.buz_ctrl[2:1]];

    // ------------------------------------------------------------------
    // pin drivers from the next register values
    // ------------------------------------------------------------------
    // open-drain pins release instead of driving high
    s_d.a_oe = s_d.a_dir & ~(s_d.a_od & s_d.a_out);
    s_d.a_o = s_d.a_out & ~s_d.a_od;
    s_d.a_pu = {4{s_d.pu_grp[`IOP_PU_A]}} & ~s_d.a_dir;
    s_d.c_oe = s_d.c_dir & ~(s_d.c_od & s_d.c_out);
    s_d.c_o = s_d.c_out & ~s_d.c_od;
    s_d.c_pu = {4{s_d.pu_grp[`IOP_PU_C]}} & ~s_d.c_dir;
    s_d.e_oe = s_d.e_dir & ~(s_d.e_od & s_d.e_out);
    s_d.e_o = s_d.e_out & ~s_d.e_od;
    s_d.e_pu = {3{s_d.pu_grp[`IOP_PU_E]}} & ~s_d.e_dir;
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      s_q.edge_sel <= `IOP_RST_SEL;
      s_q.mask <= `IOP_RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign NIBBLE_PORT_A_PINS_O = s_q.a_o;
  assign NIBBLE_PORT_A_PINS_OE = s_q.a_oe;
  assign NIBBLE_PORT_A_PINS_PU = s_q.a_pu;
  assign INPUT_ONLY_PORT_PINS_PU = s_q.b_pu;
  assign NIBBLE_PORT_C_PINS_O = s_q.c_o;
  assign NIBBLE_PORT_C_PINS_OE = s_q.c_oe;
  assign NIBBLE_PORT_C_PINS_PU = s_q.c_pu;
  assign THREE_PIN_PORT_PINS_O = s_q.e_o;
  assign THREE_PIN_PORT_PINS_OE = s_q.e_oe;
  assign THREE_PIN_PORT_PINS_PU = s_q.e_pu;
  assign SEGMENT_SHARED_OUTPUT_PINS = s_q.seg;
  assign IRQ = s_q.irq;
  assign BUZZER_OUTPUT = s_q.buzzer_output;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  a_rd_pins_a: assert property (RD && ADDR == `IOP_A_IN |=>
    RDATA == {4'h0, $past(NIBBLE_PORT_A_PINS_I)}) else $error("port A read wrong");
  a_input_no_drive: assert property ((NIBBLE_PORT_A_PINS_OE & ~s_q.a_dir) == 4'h0)
    else $error("input pin driven");
  a_od_never_high: assert property ((NIBBLE_PORT_A_PINS_OE & NIBBLE_PORT_A_PINS_O
    & s_q.a_od) == 4'h0) else $error("open-drain pin driven high");
  a_pull_off_out: assert property ((NIBBLE_PORT_A_PINS_PU & s_q.a_dir) == 4'h0
    && NIBBLE_PORT_A_PINS_PU == ({4{s_q.pu_grp[0]}} & ~s_q.a_dir))
    else $error("pull-up on output pin");
  a_b_pullups: assert property (WR && ADDR == `IOP_B_PU |=>
    INPUT_ONLY_PORT_PINS_PU == $past(WDATA[3:0])) else $error("input pull-up not set");
  a_wide_write: assert property (WR && ADDR == `IOP_AC_WIDE |=>
    {s_q.c_out, s_q.a_out} == $past(WDATA)) else $error("wide write lost");
  a_e_pull_off: assert property ((THREE_PIN_PORT_PINS_PU & s_q.e_dir) == 3'h0)
    else $error("three-pin pull-up on output");
  a_seg_write: assert property (WR && ADDR == `IOP_SEG_OUT |=>
    SEGMENT_SHARED_OUTPUT_PINS == $past(WDATA)) else $error("segment write lost");
  a_key_edge: assert property (|(rise[3:0] & s_q.edge_sel[3:0]) |=>
    s_q.status[`IOP_ST_KEY]) else $error("key edge missed");
  a_exta_edge: assert property (!s_q.edge_sel[`IOP_SEL_EXTA] && fall[4] |=>
    s_q.status[`IOP_ST_EXTA]) else $error("external edge missed");
  a_quasi_silent: assert property (s_q.status[`IOP_ST_QUASI]
    && (s_q.status & 5'h17) == 5'h00 |-> !IRQ)
    else $error("quasi flag raised interrupt");
  a_both_edge: assert property (s_q.sync2[7] != s_q.prev[7] |=>
    s_q.status[`IOP_ST_BOTH]) else $error("both-edge event missed");
  a_buz_tick: assert property ($changed(s_q.bcnt) && s_q.buz_ctrl[0] |->
    $past(tick) || $past(!s_q.buz_ctrl[0])) else $error("buzzer stepped off tick");
  a_sync_delay: assert property ($rose(INPUT_ONLY_PORT_PINS_I[3]) |->
    ##3 s_q.status[`IOP_ST_BOTH]) else $error("edge not flagged in three cycles");

endmodule : iop_ports

// ### tb/iop_board.sv
// board model: resolves each port pin from device drive, board source and pull-up
`timescale 1ns/1ps
module iop_board #(
  parameter int W = 4
) (
  // clock for the floating-line model
  input wire logic clk,
  // device drive
  input wire logic [W-1:0] o,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu,
  // board source, driven through a resistor so the device wins
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] ext_en,
  // resolved level
  output logic [W-1:0] pin
);
  logic [W-1:0] last_q = '0;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) pin[i] = o[i];
      else if (ext_en[i]) pin[i] = ext[i];
      else if (pu[i]) pin[i] = 1'b1;
      else pin[i] = ~last_q[i];  // floating: never a stable value to rely on
    end
  end
  always @(posedge clk) last_q <= pin;
endmodule : iop_board

// ### tb/testbench.sv
// self-checking bench for the io port block
`timescale 1ns/1ps
`include "iop_consts.svh"
module testbench;
  localparam int WDIV = 4;
  logic MCLK, RESET, WR, RD, irq, buzzer_output;
  logic [7:0] ADDR, WDATA, RDATA, seg, ms;
  logic [3:0] pa, pb, pc, ao, aoe, apu, bpu, co, coe, cpu, xa, xb, xc, xbe, ea, ec;
  logic [3:0] mo[3], md[3], mz[3];
  logic [2:0] pe, eo, eoe, epu, xe, grp;
  logic [7:0] base[3] = '{`IOP_A_OUT, `IOP_C_OUT, `IOP_E_OUT};
  logic [31:0] v;
  int seed = 49, err_total = 0, check_count = 0, n, h;
  iop_ports #(.WATCH_DIV(WDIV)) uut (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .NIBBLE_PORT_A_PINS_I(pa), .NIBBLE_PORT_A_PINS_O(ao),
    .NIBBLE_PORT_A_PINS_OE(aoe), .NIBBLE_PORT_A_PINS_PU(apu), .INPUT_ONLY_PORT_PINS_I(pb),
    .INPUT_ONLY_PORT_PINS_PU(bpu), .NIBBLE_PORT_C_PINS_I(pc), .NIBBLE_PORT_C_PINS_O(co),
    .NIBBLE_PORT_C_PINS_OE(coe), .NIBBLE_PORT_C_PINS_PU(cpu), .THREE_PIN_PORT_PINS_I(pe),
    .THREE_PIN_PORT_PINS_O(eo), .THREE_PIN_PORT_PINS_OE(eoe), .THREE_PIN_PORT_PINS_PU(epu),
    .SEGMENT_SHARED_OUTPUT_PINS(seg), .IRQ(irq), .BUZZER_OUTPUT(buzzer_output));
  iop_board bd_a (.clk(MCLK), .o(ao), .oe(aoe), .pu(apu), .ext(xa), .ext_en(ea), .pin(pa));
  iop_board bd_b (.clk(MCLK), .o(4'h0), .oe(4'h0), .pu(bpu), .ext(xb), .ext_en(xbe), .pin(pb));
  iop_board bd_c (.clk(MCLK), .o(co), .oe(coe), .pu(cpu), .ext(xc), .ext_en(ec), .pin(pc));
  iop_board #(.W(3)) bd_e (.clk(MCLK), .o(eo), .oe(eoe), .pu(epu), .ext(xe),
    .ext_en(3'h7), .pin(pe));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk($sformatf("read %h", a), {8'h0, e}, {8'h0, RDATA & m});
  endtask : chk_rd
  // expected {out, enable, pull-up} of one bidirectional port from the model
  function automatic logic [11:0] exp_port(input int p);
    logic [3:0] m;
    m = (p == 2) ? 4'h7 : 4'hF;
    return {md[p] & ~mz[p] & mo[p] & m, md[p] & ~(mz[p] & mo[p]) & m, grp[p] ? ~md[p] & m : 4'h0};
  endfunction : exp_port
  task automatic port_chk(input int p);
    logic [11:0] e, g;
    e = exp_port(p);
    g = (p == 0) ? {ao, aoe, apu} : (p == 1) ? {co, coe, cpu} : {1'b0, eo, 1'b0, eoe, 1'b0, epu};
    chk($sformatf("port %0d", p), {4'h0, e}, {4'h0, g[11:8] & e[7:4], g[7:0]});
  endtask : port_chk
  function automatic logic [7:0] pin_exp(input int p);
    logic [11:0] e;
    logic [3:0] x;
    e = exp_port(p);
    x = (p == 0) ? xa : (p == 1) ? xc : {1'b0, xe};
    return {4'h0, ((e[7:4] & e[11:8]) | (~e[7:4] & x)) & ((p == 2) ? 4'h7 : 4'hF)};
  endfunction : pin_exp
  task automatic settle;
    repeat (4) @(posedge MCLK);
    #1;
  endtask : settle
  task automatic wait_lv(input logic l, output int c);
    c = 0;
    do begin
      @(posedge MCLK);
      #1;
      c++;
    end while (buzzer_output !== l && c < 500);
  endtask : wait_lv
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #300000;
    err_total++;
    wrap_up();
  end
  initial begin
    {RESET, WR, RD, ADDR, WDATA, xa, xb, xc, xe, xbe, grp, ms} = {1'b1, 33'h0, 4'hF, 11'h0};
    {ea, ec} = 8'hFF;
    foreach (mo[p]) {mo[p], md[p], mz[p]} = 12'h0;
    repeat (3) @(posedge MCLK);
    RESET <= 1'b0;
    #1;
    for (int p = 0; p < 3; p++) port_chk(p);
    chk("reset misc", 16'h0, {2'h0, irq, buzzer_output, bpu, seg});
    chk_rd(8'hFF, 8'h00, 8'hFF);
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      @(posedge MCLK);
      v = $random(seed);
      {xa, xc, xe, grp} <= v[13:0];
      wr(`IOP_PU_GRP, {5'h0, v[2:0]});
      for (int p = 0; p < 3; p++) begin
        v = $random(seed);
        {mo[p], md[p], mz[p]} = v[11:0];
        wr(base[p], {4'h0, mo[p]});
        wr(base[p] + 8'h1, {4'h0, md[p]});
        wr(base[p] + 8'h2, {4'h0, mz[p]});
      end
      for (int p = 0; p < 3; p++) begin
        port_chk(p);
        chk_rd(base[p] + 8'h3, pin_exp(p), 8'hFF);
      end
    end
    $display("test ports done");
    for (int p = 0; p < 2; p++) begin
      {md[p], mz[p]} = 8'hF0;
      wr(base[p] + 8'h1, 8'h0F);
      wr(base[p] + 8'h2, 8'h00);
    end
    v = $random(seed);
    {mo[1], mo[0], ms} = v[15:0];
    wr(`IOP_AC_WIDE, v[15:8]);
    wr(`IOP_SEG_OUT, v[7:0]);
    chk_rd(`IOP_AC_WIDE, v[15:8], 8'hFF);
    for (int r = 0; r < 24; r++) begin
      v = $random(seed);
      wr(`IOP_BIT_WR, {v[7:3], 2'b0, v[0]});
      if (v[7:6] == 2'h3) ms[v[5:3]] = v[0];
      else if (v[5:3] < ((v[7:6] == 2'h2) ? 3 : 4)) mo[v[7:6]][v[5:3]] = v[0];
      for (int p = 0; p < 3; p++) port_chk(p);
      chk("seg", {8'h0, ms}, {8'h0, seg});
    end
    $display("test wide and bit done");
    @(posedge MCLK);
    xbe <= 4'h0;
    v = $random(seed);
    wr(`IOP_B_PU, {4'h0, v[3:0]});
    chk("input pull-ups", {12'h0, v[3:0]}, {12'h0, bpu});
    chk_rd(`IOP_B_IN, {4'h0, v[3:0]}, {4'h0, v[3:0]});
    @(posedge MCLK);
    {xbe, xb} <= {4'hF, v[7:4]};
    chk_rd(`IOP_B_IN, {4'h0, v[7:4]}, 8'hFF);
    $display("test input port done");
    wr(`IOP_A_DIR, 8'h00);
    md[0] = 4'h0;
    @(posedge MCLK);
    {ea, grp} <= 7'h01;
    wr(`IOP_PU_GRP, 8'h01);
    chk_rd(`IOP_A_IN, 8'h0F, 8'hFF);
    @(posedge MCLK);
    {xa, xb, ea} <= 12'hF0F;
    wr(`IOP_IRQ_MASK, 8'h1F);
    wr(`IOP_EDGE_SEL, 8'h70);
    chk_rd(`IOP_IRQ_MASK, 8'h1F, 8'hFF);
    chk_rd(`IOP_IRQ_ST, 8'h00, 8'h00);
    @(posedge MCLK);
    xb <= 4'hF;
    settle();
    chk("irq set", 16'h1, {15'h0, irq});
    chk_rd(`IOP_IRQ_ST, 8'h1E, 8'hFF);
    chk_rd(`IOP_IRQ_ST, 8'h00, 8'hFF);
    chk("irq clear", 16'h0, {15'h0, irq});
    @(posedge MCLK);
    xb <= 4'h0;
    settle();
    chk_rd(`IOP_IRQ_ST, 8'h10, 8'hFF);
    @(posedge MCLK);
    xa <= 4'h7;
    settle();
    chk_rd(`IOP_IRQ_ST, 8'h01, 8'hFF);
    @(posedge MCLK);
    xa <= 4'hF;
    settle();
    chk_rd(`IOP_IRQ_ST, 8'h00, 8'hFF);
    wr(`IOP_IRQ_MASK, 8'h08);
    @(posedge MCLK);
    xb <= 4'h4;
    settle();
    chk("quasi irq", 16'h0, {15'h0, irq});
    chk_rd(`IOP_IRQ_ST, 8'h08, 8'hFF);
    // other polarities: key pin 0 rising, ext and quasi falling
    wr(`IOP_EDGE_SEL, 8'h01);
    @(posedge MCLK);
    {xa, xb} <= 8'hE0;
    settle();
    chk_rd(`IOP_IRQ_ST, 8'h08, 8'hFF);
    @(posedge MCLK);
    {xa, xb} <= 8'hF3;
    settle();
    chk_rd(`IOP_IRQ_ST, 8'h01, 8'hFF);
    @(posedge MCLK);
    xb <= 4'h0;
    settle();
    chk_rd(`IOP_IRQ_ST, 8'h06, 8'hFF);
    $display("test interrupts done");
    for (int s = 0; s < 4; s++) begin
      wr(`IOP_BUZ_CTRL, {5'h0, s[1:0], 1'b1});
      wait_lv(1'b0, n);
      wait_lv(1'b1, n);
      wait_lv(1'b0, h);
      wait_lv(1'b1, n);
      chk("buzzer period", 16'(WDIV << (4 - s)), 16'(h + n));
    end
    wr(`IOP_BUZ_CTRL, 8'h00);
    settle();
    chk("buzzer off", 16'h0, {15'h0, buzzer_output});
    $display("test buzzer done");
    @(posedge MCLK);
    RESET <= 1'b1;
    @(posedge MCLK);
    RESET <= 1'b0;
    grp <= 3'h0;
    foreach (mo[p]) {mo[p], md[p], mz[p]} = 12'h0;
    #1;
    for (int p = 0; p < 3; p++) port_chk(p);
    chk("reset again", 16'h0, {2'h0, irq, buzzer_output, bpu, seg});
    chk_rd(`IOP_IRQ_ST, 8'h00, 8'hFF);
    $display("test reset again done");
    wrap_up();
  end
endmodule : testbench
